/* File: rtl/csr_core_regs.sv */
`timescale 1ns/100ps
module csr_core_regs
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // SFR byte access
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // SFR bit access
  input wire logic bit_wr,
  input wire logic [7:0] bit_addr,
  input wire logic bit_val,
  output logic bit_ok,
  // Core execution hooks
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic dp_inc,
  input wire logic mul_div_wr,
  input wire logic [7:0] mul_div_hi,
  input wire logic flags_wr,
  input wire logic [2:0] flags_in,
  input wire logic [7:0] work_value,
  input wire logic ext_stack_en,
  // Derived outputs
  output logic [10:0] stack_addr,
  output logic [23:0] data_pointer_full,
  output logic [1:0] bank_sel,
  output logic [7:0] aux_operand,
  output logic [7:0] power_control
);
  csr_stack_if sif();
  logic [7:0] aux_q, aux_d;
  logic [7:0] stk_lo_q, stk_lo_d;
  logic [7:0] stk_hi_q, stk_hi_d;
  logic [7:0] dp_page_q, dp_page_d, dp_high_q, dp_high_d, dp_low_q, dp_low_d;
  logic [7:0] status_q, status_d;
  logic [7:0] pwr_ctl_q, pwr_ctl_d;
  logic [7:0] rdata_q, rdata_d;
  logic bit_ok_q, bit_ok_d;
  logic [23:0] dp_sum;
  logic [7:0] bit_target;

  // Bit-addressable only when low nibble is 0 or 8
  function automatic logic bit_capable(input logic [7:0] a);
    bit_capable = (a[3:0] == csr_pkg::NIB_BIT_A) || (a[3:0] == csr_pkg::NIB_BIT_B);
  endfunction : bit_capable

  function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] i,
    input logic b);
    set_bit = v;
    set_bit[i] = b;
  endfunction : set_bit

  assign sif.push = stack_push;
  assign sif.pop = stack_pop;
  assign sif.ext_en = ext_stack_en;
  assign sif.low_q = stk_lo_q;
  assign sif.high_q = stk_hi_q[2:0];

  csr_stack_step u_step
  (
    .sif(sif)
  );

  always_comb
  begin
    aux_d = aux_q;
    stk_lo_d = stk_lo_q;
    stk_hi_d = stk_hi_q;
    dp_page_d = dp_page_q;
    dp_high_d = dp_high_q;
    dp_low_d = dp_low_q;
    status_d = status_q;
    pwr_ctl_d = pwr_ctl_q;
    bit_ok_d = 1'b0;
    dp_sum = 24'({dp_page_q, dp_high_q, dp_low_q} + 24'h00_0001);
    bit_target = {bit_addr[7:3], 3'b000};
    // Byte writes; unmapped addresses fall through untouched
    if (sfr_wr)
    begin
      unique case (sfr_addr)
        csr_pkg::ADDR_AUX_OPERAND: aux_d = sfr_wdata;
        csr_pkg::ADDR_STACK_LOW: stk_lo_d = sfr_wdata;
        csr_pkg::ADDR_STACK_HIGH: stk_hi_d = sfr_wdata;
        csr_pkg::ADDR_DP_PAGE: dp_page_d = sfr_wdata;
        csr_pkg::ADDR_DP_HIGH: dp_high_d = sfr_wdata;
        csr_pkg::ADDR_DP_LOW: dp_low_d = sfr_wdata;
        csr_pkg::ADDR_STATUS_WORD: status_d = sfr_wdata;
        csr_pkg::ADDR_POWER_CONTROL: pwr_ctl_d = sfr_wdata;
        default: ;
      endcase
    end
    // Bit writes land only where a bit-capable register holds storage
    if (bit_wr && bit_capable(bit_target))
    begin
      if (bit_target == csr_pkg::ADDR_STATUS_WORD)
      begin
        bit_ok_d = 1'b1;
        status_d = set_bit(status_q, bit_addr[2:0], bit_val);
      end
      else if (bit_target == csr_pkg::ADDR_AUX_OPERAND)
      begin
        bit_ok_d = 1'b1;
        aux_d = set_bit(aux_q, bit_addr[2:0], bit_val);
      end
    end
    if (mul_div_wr)
      aux_d = mul_div_hi;
    if (flags_wr)
    begin
      status_d[csr_pkg::STATUS_CARRY] = flags_in[2];
      status_d[csr_pkg::STATUS_NIBBLE] = flags_in[1];
      status_d[csr_pkg::STATUS_SIGNED] = flags_in[0];
    end
    if (stack_push || stack_pop)
    begin
      stk_lo_d = sif.low_d;
      stk_hi_d = {stk_hi_q[7:3], sif.high_d};
    end
    if (dp_inc)
      {dp_page_d, dp_high_d, dp_low_d} = dp_sum;
    status_d[csr_pkg::STATUS_PARITY] = ^work_value;
    // Read mux; unoccupied addresses give a fixed filler
    rdata_d = csr_pkg::UNMAPPED_READ;
    if (sfr_rd)
    begin
      unique case (sfr_addr)
        csr_pkg::ADDR_AUX_OPERAND: rdata_d = aux_q;
        csr_pkg::ADDR_STACK_LOW: rdata_d = stk_lo_q;
        csr_pkg::ADDR_STACK_HIGH: rdata_d = stk_hi_q;
        csr_pkg::ADDR_DP_PAGE: rdata_d = dp_page_q;
        csr_pkg::ADDR_DP_HIGH: rdata_d = dp_high_q;
        csr_pkg::ADDR_DP_LOW: rdata_d = dp_low_q;
        csr_pkg::ADDR_STATUS_WORD: rdata_d = {status_q[7:1], ^work_value};
        csr_pkg::ADDR_POWER_CONTROL: rdata_d = pwr_ctl_q;
        default: rdata_d = csr_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      aux_q <= csr_pkg::RST_ZERO;
      stk_lo_q <= csr_pkg::RST_STACK_LOW;
      stk_hi_q <= csr_pkg::RST_ZERO;
      dp_page_q <= csr_pkg::RST_ZERO;
      dp_high_q <= csr_pkg::RST_ZERO;
      dp_low_q <= csr_pkg::RST_ZERO;
      status_q <= csr_pkg::RST_STATUS_WORD;
      pwr_ctl_q <= csr_pkg::RST_POWER_CONTROL;
      rdata_q <= csr_pkg::RST_ZERO;
      bit_ok_q <= 1'b0;
    end
    else
    begin
      aux_q <= aux_d;
      stk_lo_q <= stk_lo_d;
      stk_hi_q <= stk_hi_d;
      dp_page_q <= dp_page_d;
      dp_high_q <= dp_high_d;
      dp_low_q <= dp_low_d;
      status_q <= status_d;
      pwr_ctl_q <= pwr_ctl_d;
      rdata_q <= rdata_d;
      bit_ok_q <= bit_ok_d;
    end
  end

  assign sfr_rdata = rdata_q;
  assign bit_ok = bit_ok_q;
  assign stack_addr = {stk_hi_q[2:0], stk_lo_q};
  assign data_pointer_full = {dp_page_q, dp_high_q, dp_low_q};
  assign bank_sel = {status_q[csr_pkg::STATUS_BANK_HI], status_q[csr_pkg::STATUS_BANK_LO]};
  assign aux_operand = aux_q;
  assign power_control = pwr_ctl_q;

  a_reset_stack: assert property (@(posedge ref_clk)
    srst |=> stk_lo_q == csr_pkg::RST_STACK_LOW)
    else $error("stack low not 07 after reset");
  a_push_incr: assert property (@(posedge ref_clk) disable iff (srst)
    stack_push && !stack_pop && !ext_stack_en && !sfr_wr |=>
    stk_lo_q == 8'($past(stk_lo_q) + 8'h01))
    else $error("push did not pre-increment");
  a_ext_roll: assert property (@(posedge ref_clk) disable iff (srst)
    stack_push && !stack_pop && ext_stack_en && !sfr_wr && stk_lo_q == 8'hFF &&
    stk_hi_q[2:0] == 3'h0 |=> stack_addr == 11'h100)
    else $error("extended stack did not roll to 0100");
  a_data_pointer_full_carry: assert property (@(posedge ref_clk) disable iff (srst)
    dp_inc && !sfr_wr |=> data_pointer_full == 24'($past(data_pointer_full) + 24'h00_0001))
    else $error("data pointer increment wrong");
  // Antecedent keeps the reset release edge out of the check
  a_parity_even: assert property (@(posedge ref_clk) disable iff (srst)
    !srst |=> status_q[csr_pkg::STATUS_PARITY] == ^$past(work_value))
    else $error("parity does not follow accumulator");
  a_bank_track: assert property (@(posedge ref_clk) disable iff (srst)
    sfr_wr && sfr_addr == csr_pkg::ADDR_STATUS_WORD && !bit_wr |=>
    bank_sel == $past(sfr_wdata[4:3]))
    else $error("bank select mismatch");
  a_power_write: assert property (@(posedge ref_clk) disable iff (srst)
    sfr_wr && sfr_addr == csr_pkg::ADDR_POWER_CONTROL |=> power_control == $past(sfr_wdata))
    else $error("power control write lost");
  a_unmapped_write: assert property (@(posedge ref_clk) disable iff (srst)
    sfr_wr && sfr_addr == 8'hC9 && !bit_wr && !mul_div_wr && !dp_inc &&
    !stack_push && !stack_pop && !flags_wr |=> $stable(aux_q) && $stable(power_control)
    && $stable(data_pointer_full) && $stable(stack_addr) && $stable(bank_sel))
    else $error("unmapped write changed state");
  a_bit_gate: assert property (@(posedge ref_clk) disable iff (srst)
    bit_wr && {bit_addr[7:3], 3'b000} != csr_pkg::ADDR_STATUS_WORD &&
    {bit_addr[7:3], 3'b000} != csr_pkg::ADDR_AUX_OPERAND |=> !bit_ok)
    else $error("bit access on non bit register");
  a_bit_accept: assert property (@(posedge ref_clk) disable iff (srst)
    bit_wr && {bit_addr[7:3], 3'b000} == csr_pkg::ADDR_STATUS_WORD |=> bit_ok)
    else $error("status bit write not accepted");
  a_aux_muldiv: assert property (@(posedge ref_clk) disable iff (srst)
    mul_div_wr |=> aux_operand == $past(mul_div_hi))
    else $error("aux operand not loaded");
endmodule : csr_core_regs

/* File: rtl/csr_pkg.sv */
package csr_pkg;
  // SFR addresses
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_STACK_LOW = 8'h81;
  localparam logic [7:0] ADDR_DP_LOW = 8'h82;
  localparam logic [7:0] ADDR_DP_HIGH = 8'h83;
  localparam logic [7:0] ADDR_DP_PAGE = 8'h84;
  localparam logic [7:0] ADDR_STACK_HIGH = 8'hB7;
  localparam logic [7:0] ADDR_STATUS_WORD = 8'hD0;
  localparam logic [7:0] ADDR_AUX_OPERAND = 8'hF0;
  localparam logic [7:0] ADDR_MAIN_WORK = 8'hE0;
  // Reset values
  localparam logic [7:0] RST_STACK_LOW = 8'h07;
  localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] RST_STATUS_WORD = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'hFF;
  // Status word fields
  localparam int STATUS_CARRY = 7;
  localparam int STATUS_NIBBLE = 6;
  localparam int STATUS_UFLAG0 = 5;
  localparam int STATUS_BANK_HI = 4;
  localparam int STATUS_BANK_LO = 3;
  localparam int STATUS_SIGNED = 2;
  localparam int STATUS_UFLAG1 = 1;
  localparam int STATUS_PARITY = 0;
  // Power control fields
  localparam int PC_BAUD = 7;
  localparam int PC_SER_WAKE = 6;
  localparam int PC_EXT_WAKE = 5;
  localparam int PC_ALE_OFF = 4;
  localparam int PC_PWR_DOWN = 1;
  localparam int PC_IDLE = 0;
  localparam int STACK_HIGH_BITS = 3;
  localparam logic [2:0] STACK_EXT_BASE = 3'h1;
  localparam logic [3:0] NIB_BIT_A = 4'h0;
  localparam logic [3:0] NIB_BIT_B = 4'h8;
  typedef enum logic [1:0] {OP_NONE, OP_PUSH, OP_POP} csr_stack_op_t;
endpackage : csr_pkg

/* File: rtl/csr_stack_if.sv */
`timescale 1ns/100ps
interface csr_stack_if;
  logic push;
  logic pop;
  logic ext_en;
  logic [7:0] low_q;
  logic [2:0] high_q;
  logic [7:0] low_d;
  logic [2:0] high_d;
  modport core(output push, output pop, output ext_en, output low_q, output high_q,
    input low_d, input high_d);
  modport unit(input push, input pop, input ext_en, input low_q, input high_q,
    output low_d, output high_d);
endinterface : csr_stack_if

/* File: rtl/csr_stack_step.sv */
`timescale 1ns/100ps
module csr_stack_step
(
  csr_stack_if.unit sif
);
  logic [10:0] next_ptr;
  always_comb
  begin
    next_ptr = {sif.high_q, sif.low_q};
    if (sif.push)
    begin
      // Pre-increment, then data is written at the new pointer
      if (!sif.ext_en)
        next_ptr = {sif.high_q, 8'(sif.low_q + 8'h01)};
      else if (sif.low_q == 8'hFF && sif.high_q == 3'h0)
        next_ptr = {csr_pkg::STACK_EXT_BASE, 8'h00};
      else
        next_ptr = 11'({sif.high_q, sif.low_q} + 11'h001);
    end
    else if (sif.pop)
    begin
      if (!sif.ext_en)
        next_ptr = {sif.high_q, 8'(sif.low_q - 8'h01)};
      else if (sif.low_q == 8'h00 && sif.high_q == csr_pkg::STACK_EXT_BASE)
        next_ptr = {3'h0, 8'hFF};
      else
        next_ptr = 11'({sif.high_q, sif.low_q} - 11'h001);
    end
    sif.low_d = next_ptr[7:0];
    sif.high_d = next_ptr[10:8];
  end
endmodule : csr_stack_step

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, bit_wr = 1'b0, bit_val = 1'b0;
  localparam int HOOK_PUSH = 0;
  localparam int HOOK_POP = 1;
  localparam int HOOK_DP = 2;
  localparam int HOOK_MULDIV = 3;
  localparam int HOOK_FLAGS = 4;
  logic stack_push = 1'b0, stack_pop = 1'b0, dp_inc = 1'b0;
  logic mul_div_wr = 1'b0, flags_wr = 1'b0, ext_stack_en = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00;
  logic [7:0] mul_div_hi = 8'h00, work_value = 8'h00;
  logic [2:0] flags_in = 3'h0;
  logic [7:0] sfr_rdata, aux_operand, power_control;
  logic bit_ok;
  logic [10:0] stack_addr;
  logic [23:0] data_pointer_full;
  logic [1:0] bank_sel;
  int mismatches = 0;
  int checks = 0;

  csr_core_regs i_csr_core_regs (.ref_clk(ref_clk), .srst(srst), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .bit_wr(bit_wr), .bit_addr(bit_addr), .bit_val(bit_val), .bit_ok(bit_ok),
    .stack_push(stack_push), .stack_pop(stack_pop), .dp_inc(dp_inc),
    .mul_div_wr(mul_div_wr), .mul_div_hi(mul_div_hi), .flags_wr(flags_wr),
    .flags_in(flags_in), .work_value(work_value), .ext_stack_en(ext_stack_en),
    .stack_addr(stack_addr), .data_pointer_full(data_pointer_full), .bank_sel(bank_sel),
    .aux_operand(aux_operand), .power_control(power_control));

  always #5 ref_clk = ~ref_clk;

  task print_verdict;
    $display("Checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
    #1;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    #1;
    check({16'h0000, sfr_rdata}, {16'h0000, exp});
  endtask : rd

  task bwr(input logic [7:0] a, input logic v, input logic ok);
    @(posedge ref_clk);
    bit_wr <= 1'b1;
    bit_addr <= a;
    bit_val <= v;
    @(posedge ref_clk);
    bit_wr <= 1'b0;
    #1;
    check({23'h0, bit_ok}, {23'h0, ok});
  endtask : bwr

  // Hooks are level: one cycle high gives exactly one step
  task pulse(input int hook);
    @(posedge ref_clk);
    case (hook)
      HOOK_PUSH: stack_push <= 1'b1;
      HOOK_POP: stack_pop <= 1'b1;
      HOOK_DP: dp_inc <= 1'b1;
      HOOK_MULDIV: mul_div_wr <= 1'b1;
      HOOK_FLAGS: flags_wr <= 1'b1;
      default: ;
    endcase
    @(posedge ref_clk);
    stack_push <= 1'b0;
    stack_pop <= 1'b0;
    dp_inc <= 1'b0;
    mul_div_wr <= 1'b0;
    flags_wr <= 1'b0;
    #1;
  endtask : pulse

  initial
  begin
    #100000;
    mismatches++;
    print_verdict();
  end

  initial
  begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    rd(csr_pkg::ADDR_STACK_LOW, 8'h07);
    check({13'h0, stack_addr}, 24'h00_0007);
    rd(csr_pkg::ADDR_POWER_CONTROL, 8'h00);
    rd(csr_pkg::ADDR_STATUS_WORD, 8'h00);
    pulse(HOOK_PUSH);
    check({13'h0, stack_addr}, 24'h00_0008);
    wr(csr_pkg::ADDR_POWER_CONTROL, 8'h5A);
    check({16'h0000, power_control}, 24'h00_005A);
    rd(csr_pkg::ADDR_POWER_CONTROL, 8'h5A);
    // Read data stands one cycle, then falls back to the filler
    @(posedge ref_clk);
    #1;
    check({16'h0000, sfr_rdata}, {16'h0000, csr_pkg::UNMAPPED_READ});
    wr(csr_pkg::ADDR_STACK_LOW, 8'hFF);
    wr(csr_pkg::ADDR_STACK_HIGH, 8'h05);
    check({13'h0, stack_addr}, 24'h00_05FF);
    wr(csr_pkg::ADDR_STACK_HIGH, 8'h00);
    ext_stack_en <= 1'b1;
    pulse(HOOK_PUSH);
    check({13'h0, stack_addr}, 24'h00_0100);
    pulse(HOOK_POP);
    check({13'h0, stack_addr}, 24'h00_00FF);
    wr(csr_pkg::ADDR_DP_LOW, 8'hFF);
    wr(csr_pkg::ADDR_DP_HIGH, 8'hFF);
    wr(csr_pkg::ADDR_DP_PAGE, 8'h12);
    check(data_pointer_full, 24'h12_FFFF);
    pulse(HOOK_DP);
    check(data_pointer_full, 24'h13_0000);
    rd(csr_pkg::ADDR_DP_PAGE, 8'h13);
    wr(csr_pkg::ADDR_AUX_OPERAND, 8'h3C);
    rd(csr_pkg::ADDR_AUX_OPERAND, 8'h3C);
    mul_div_hi <= 8'h99;
    pulse(HOOK_MULDIV);
    check({16'h0000, aux_operand}, 24'h00_0099);
    bwr(8'hF1, 1'b1, 1'b1);
    check({16'h0000, aux_operand}, 24'h00_009B);
    for (int b = 0; b < 4; b++)
    begin
      wr(csr_pkg::ADDR_STATUS_WORD, 8'(b << 3));
      check({22'h0, bank_sel}, 24'(b));
    end
    work_value <= 8'h07;
    // Status write tries to clear parity; live parity must win
    wr(csr_pkg::ADDR_STATUS_WORD, 8'h18);
    rd(csr_pkg::ADDR_STATUS_WORD, 8'h19);
    bwr(8'hD5, 1'b1, 1'b1);
    rd(csr_pkg::ADDR_STATUS_WORD, 8'h39);
    flags_in <= 3'b101;
    pulse(HOOK_FLAGS);
    rd(csr_pkg::ADDR_STATUS_WORD, 8'hBD);
    // Unoccupied address only; test locations are never touched
    wr(8'hC9, 8'hA5);
    rd(8'hC9, csr_pkg::UNMAPPED_READ);
    check({16'h0000, power_control}, 24'h00_005A);
    bwr(8'h81, 1'b1, 1'b0);
    bwr(8'h3A, 1'b1, 1'b0);
    rd(csr_pkg::ADDR_AUX_OPERAND, 8'h9B);
    rd(csr_pkg::ADDR_STATUS_WORD, 8'hBD);
    // Mid-run reset must bring back the start values
    @(posedge ref_clk);
    srst <= 1'b1;
    ext_stack_en <= 1'b0;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rd(csr_pkg::ADDR_POWER_CONTROL, csr_pkg::RST_POWER_CONTROL);
    check({13'h0, stack_addr}, 24'h00_0007);
    check(data_pointer_full, 24'h00_0000);
    pulse(HOOK_PUSH);
    check({13'h0, stack_addr}, 24'h00_0008);
    pulse(HOOK_POP);
    check({13'h0, stack_addr}, 24'h00_0007);
    rd(csr_pkg::ADDR_STATUS_WORD, 8'h01);
    print_verdict();
  end
endmodule : tb_top
